// file: iosw_host_model.sv
/* Host model: kicks the watchdog every PERIOD cycles and requests traffic while running.
   Assumes the bench starts it only after reset is released. */
`timescale 1ns/1ns
module iosw_host_model #(
  parameter int PERIOD = 5
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  output logic      kick_o,
  output logic      host_req_o
);
  int cnt_q;
  assign host_req_o = run_i;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_q  <= 0;
      kick_o <= 1'b0;
    end else begin
      cnt_q  <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      kick_o <= run_i && (cnt_q == 0);
    end
  end
endmodule

// file: iosw_pkg.sv
/*
  Package for the I/O safety watchdog: timing constants, pin group carrier and state encoding.
  Assumes a single 125 MHz device clock and a host that reaches the block through plain ports.
*/
package iosw_pkg;
  localparam int unsigned NS_PER_CYCLE       = 8;
  localparam logic [31:0] TIMEOUT_RESET_NS   = 32'h3B9A_CA00;
  localparam int          TIMER_W            = 32;
  localparam logic [31:0] TIMER_ZERO         = 32'h0000_0000;
  localparam logic [31:0] TIMER_ONE          = 32'h0000_0001;

  typedef enum logic [1:0] {
    IOSW_ST_ARMED = 2'b00,
    IOSW_ST_FIRED = 2'b01
  } iosw_state_e;

  // One pin's request from its function unit.
  typedef struct packed {
    logic out;
    logic oe_n;
  } iosw_pin_s;
endpackage

// file: iosw_watchdog.sv
/*
  I/O safety watchdog: counts down from the programmed timeout, fires when the host stops kicking,
  releases every pin to a pulled-high input and blocks host traffic until the fired flag is cleared.
  Assumes synchronous inputs on ref_clk_i; weak pull-ups sit on the pads outside this block.
*/
// Summary of operation
// - The watchdog can fire only when the ENABLE parameter is set, and otherwise the fired state is never entered.
// - On firing every pin is detached from its unit and becomes a pulled-high input.
// - On firing all host communication is blocked until the fired flag is cleared.
// - Firing changes only pin routing and host traffic, so function units keep running and counting.
// - PWM and step waveforms keep running inside but never reach the pins while fired.
// - Clearing the fired flag resumes host traffic and restores the load-time pin routing.
// - The fired flag reads true after firing and the host clears it by writing false.
// - The timeout is an unsigned 32-bit nanosecond value that starts at one second.
// - The block fires when more than the timeout has passed since the last kick.
// - Each kick while armed restarts the timer for a full timeout period; kicks while fired are ignored.
`timescale 1ns/1ns
module iosw_watchdog #(
  parameter int          NUM_PINS = 72,
  parameter bit          ENABLE   = 1'b1
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          kick_i,
  input  wire logic                          timeout_we_i,
  input  wire logic [31:0]                   bite_timeout_nanos_i,
  output logic      [31:0]                   bite_timeout_nanos_o,
  input  wire logic                          fired_we_i,
  input  wire logic                          fired_wdata_i,
  output logic                               fired_o,
  input  wire logic                          host_req_i,
  output logic                               host_req_o,
  input  wire iosw_pkg::iosw_pin_s [NUM_PINS-1:0] unit_pin_i,
  output logic      [NUM_PINS-1:0]           pin_out_o,
  output logic      [NUM_PINS-1:0]           pin_oe_n_o
);
  import iosw_pkg::*;

  function automatic logic [31:0] ns_to_cycles(input logic [31:0] ns);
    // Rounds down, so the loaded count exceeds the asked time only below 8 ns, where the one-cycle minimum is loaded.
    logic [31:0] c;
    c = ns / NS_PER_CYCLE;
    ns_to_cycles = (c == TIMER_ZERO) ? TIMER_ONE : c;
  endfunction

  logic [31:0] timeout_q, timeout_d;
  logic [31:0] count_q, count_d;
  iosw_state_e state_q, state_d;

  always_comb begin
    timeout_d = timeout_q;
    count_d   = count_q;
    state_d   = state_q;
    if (timeout_we_i) begin
      timeout_d = bite_timeout_nanos_i;
    end
    case (state_q)
      IOSW_ST_ARMED: begin
        if (kick_i) begin
          count_d = ns_to_cycles(timeout_d);
        end else if (count_q == TIMER_ZERO) begin
          state_d = IOSW_ST_FIRED;
        end else begin
          count_d = count_q - TIMER_ONE;
        end
      end
      IOSW_ST_FIRED: begin
        // Kicks while fired are ignored; only the explicit clear rearms.
        if (fired_we_i && !fired_wdata_i) begin
          state_d = IOSW_ST_ARMED;
          count_d = ns_to_cycles(timeout_d);
        end
      end
      default: begin
        state_d = IOSW_ST_ARMED;
      end
    endcase
    if (!ENABLE) begin
      state_d = IOSW_ST_ARMED;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      timeout_q <= TIMEOUT_RESET_NS;
      count_q   <= TIMEOUT_RESET_NS / NS_PER_CYCLE;
      state_q   <= IOSW_ST_ARMED;
    end else begin
      timeout_q <= timeout_d;
      count_q   <= count_d;
      state_q   <= state_d;
    end
  end

  logic fired;
  assign fired                = (state_q == IOSW_ST_FIRED);
  assign fired_o              = fired;
  assign bite_timeout_nanos_o = timeout_q;
  assign host_req_o           = host_req_i && !fired;

  // Flat copies of the unit requests let the checks below compare whole pin groups at once.
  logic [NUM_PINS-1:0] unit_out;
  logic [NUM_PINS-1:0] unit_oe_n;

  // Function units are never reset or gated here, only their pins are rerouted.
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    always_comb begin
      unit_out[g]   = unit_pin_i[g].out;
      unit_oe_n[g]  = unit_pin_i[g].oe_n;
      pin_out_o[g]  = fired ? 1'b1 : unit_pin_i[g].out;
      pin_oe_n_o[g] = fired ? 1'b1 : unit_pin_i[g].oe_n;
    end
  end

  chk_fires_at_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (ENABLE && state_q == IOSW_ST_ARMED && !kick_i && count_q == TIMER_ZERO) |=> fired)
    else $error("watchdog did not fire at zero count");
  chk_kick_reloads: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (!fired && kick_i && !timeout_we_i) |=> (count_q == ns_to_cycles(timeout_q)) && !fired)
    else $error("kick did not reload the timer");
  chk_counts_down: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (!fired && !kick_i && count_q != TIMER_ZERO) |=> count_q == $past(count_q) - TIMER_ONE)
    else $error("timer did not decrement");
  chk_pins_released: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    fired |-> (&pin_oe_n_o))
    else $error("pin still driven while fired");
  chk_host_blocked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    fired |-> !host_req_o)
    else $error("host traffic passed while fired");
  chk_fired_sticks: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (fired && !(fired_we_i && !fired_wdata_i)) |=> fired)
    else $error("fired flag dropped without a clear");
  chk_clear_restores: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (fired && fired_we_i && !fired_wdata_i) |=> (!fired && pin_oe_n_o == unit_oe_n && pin_out_o == unit_out))
    else $error("clear did not restore operation");
  chk_routing_armed: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !fired |-> (pin_out_o == unit_out && pin_oe_n_o == unit_oe_n))
    else $error("pin routing altered while armed");
  chk_pins_high_fired: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    fired |-> (&pin_out_o))
    else $error("unit waveform reached a pin while fired");
  chk_timeout_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    timeout_we_i |=> bite_timeout_nanos_o == $past(bite_timeout_nanos_i))
    else $error("timeout write did not land");
  chk_timeout_holds: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !timeout_we_i |=> $stable(bite_timeout_nanos_o))
    else $error("timeout changed without a write");
  chk_clear_reloads: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (fired && fired_we_i && !fired_wdata_i && !timeout_we_i) |=> count_q == ns_to_cycles(timeout_q))
    else $error("clear did not reload the timer");
  chk_host_passes: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !fired |-> host_req_o == host_req_i)
    else $error("host traffic blocked while armed");
  chk_fire_needs_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (!fired && count_q != TIMER_ZERO) |=> !fired)
    else $error("watchdog fired before the count ran out");
  chk_disabled_quiet: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !ENABLE |-> !fired)
    else $error("watchdog fired although not built in");

  cov_fire: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(fired));
  cov_clear: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $fell(fired));
  cov_kick: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) !fired && kick_i);
  cov_write_one: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) fired && fired_we_i && fired_wdata_i);
  cov_timeout_write: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) timeout_we_i);
endmodule

// file: iosw_watchdog_tb_top.sv
/* Bench for the I/O safety watchdog: host model kicks, bench writes flags and checks pins.
   Assumes a four-pin build and an 80 ns timeout, ten clock cycles. */
`timescale 1ns/1ns
module iosw_watchdog_tb_top;
  import iosw_pkg::*;
  typedef struct { bit run; bit clr; int wt; bit fired; } iosw_row_s;
  logic              clk = 1'b0, rst_n = 1'b0, run = 1'b0, t_we = 1'b0, f_we = 1'b0, f_wd = 1'b0;
  logic [31:0]       t_ns = 32'h0, t_o;
  logic              kick, hreq, fired, hreq_o;
  logic [3:0]        p_out, p_oe_n;
  iosw_pin_s [3:0]   units = 8'h5A;
  int                n_errors = 0, comparisons = 0, cyc = 0;
  // Kicks every 5 cycles keep it armed; a silent host must trip it.
  iosw_row_s rows[5] = '{'{1, 0, 40, 0}, '{0, 0, 20, 1}, '{1, 0, 10, 1}, '{1, 1, 3, 0}, '{0, 0, 20, 1}};
  iosw_watchdog #(.NUM_PINS(4), .ENABLE(1'b1)) u_iosw_watchdog (.ref_clk_i(clk), .reset_n_i(rst_n),
    .kick_i(kick), .timeout_we_i(t_we), .bite_timeout_nanos_i(t_ns), .bite_timeout_nanos_o(t_o),
    .fired_we_i(f_we), .fired_wdata_i(f_wd), .fired_o(fired), .host_req_i(hreq), .host_req_o(hreq_o),
    .unit_pin_i(units), .pin_out_o(p_out), .pin_oe_n_o(p_oe_n));
  iosw_host_model u_iosw_host_model (.ref_clk_i(clk), .reset_n_i(rst_n), .run_i(run), .kick_o(kick),
    .host_req_o(hreq));
  initial begin
    forever #4 clk = ~clk;
  end
  // Units keep toggling so a stale pin route shows up.
  always @(posedge clk) units <= ~units;
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pins(logic f);
    logic [3:0] eo, ee;
    for (int i = 0; i < 4; i++) begin
      eo[i] = f | units[i].out;
      ee[i] = f | units[i].oe_n;
    end
    cmp("fired", {31'h0, f}, {31'h0, fired});
    cmp("host_req", {31'h0, run & ~f}, {31'h0, hreq_o});
    cmp("pin_out", {28'h0, eo}, {28'h0, p_out});
    cmp("pin_oe_n", {28'h0, ee}, {28'h0, p_oe_n});
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    pins(1'b0);
    cmp("timeout", TIMEOUT_RESET_NS, t_o);
    $display("Reset test done");
    @(posedge clk);
    t_we <= 1'b1;
    t_ns <= 32'h0000_0050;
    @(posedge clk);
    t_we <= 1'b0;
    foreach (rows[i]) begin
      run <= rows[i].run;
      f_we <= rows[i].clr;
      f_wd <= 1'b0;
      @(posedge clk);
      f_we <= 1'b0;
      repeat (rows[i].wt) @(posedge clk);
      @(negedge clk);
      pins(rows[i].fired);
      $display("Row %0d done", i);
    end
    // A clear followed at once by a write of one must leave it armed.
    @(posedge clk);
    run <= 1'b1;
    f_we <= 1'b1;
    @(posedge clk);
    f_wd <= 1'b1;
    @(posedge clk);
    f_we <= 1'b0;
    @(negedge clk);
    pins(1'b0);
    cmp("timeout", 32'h0000_0050, t_o);
    $display("Write-one test done");
    tally_and_finish();
  end
endmodule
